// ===== src/djp_axis_timer.sv
/*
  One axis timer: holds its output high from a discharge trigger until the
  synchronised threshold comparator reports the timing pin at two thirds
  of the reference, then clears its output and discharges the pin.
  Assumes the trigger is a one-cycle pulse and the threshold input is
  already synchronised to i_ref_clk.
*/
`timescale 1ns/1ps
`include "djp_cfg.svh"

module djp_axis_timer #(
  parameter int DISCH_CYC = `DJP_DISCH_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_trigger,
  input wire logic i_above_threshold,
  output logic o_timer_out,
  output logic o_discharge_oe_n
);

  localparam int CW = $clog2(DISCH_CYC + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(DISCH_CYC);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  djp_pkg::djp_axis_state_t state_r;
  djp_pkg::djp_axis_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // ------------------------------------------------
  // next state
  // ------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (i_trigger) begin
      state_nxt = djp_pkg::DJP_DISCHARGE;
      cnt_nxt = CNT_LOAD;
    end else begin
      unique case (state_r)
        djp_pkg::DJP_IDLE: begin
          state_nxt = djp_pkg::DJP_IDLE;
        end
        djp_pkg::DJP_DISCHARGE: begin
          cnt_nxt = cnt_r - CNT_ONE;
          if (cnt_r <= CNT_ONE) begin
            state_nxt = djp_pkg::DJP_CHARGE;
          end
        end
        djp_pkg::DJP_CHARGE: begin
          if (i_above_threshold) begin
            state_nxt = djp_pkg::DJP_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------
  // state and pin flops
  // ------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= djp_pkg::DJP_IDLE;
      cnt_r <= '0;
      o_timer_out <= 1'b0;
      o_discharge_oe_n <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_timer_out <= (state_nxt != djp_pkg::DJP_IDLE);
      o_discharge_oe_n <= (state_nxt == djp_pkg::DJP_CHARGE);
    end
  end

endmodule

// ===== src/djp_cfg.svh
/*
  Constants for the dual joystick port: configuration indices, field
  positions, reset values and timing counts.
  Assumes it is included by bare name wherever these names are used.
*/
`ifndef DJP_CFG_SVH
`define DJP_CFG_SVH

// ------------------------------------------------
// configuration indices
// ------------------------------------------------
`define DJP_IDX_BASE_HI 8'h60
`define DJP_IDX_BASE_LO 8'h61
`define DJP_IDX_ACTIVATE 8'h30
`define DJP_IDX_PWR_CTRL 8'h22

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define DJP_ACT_BIT 0
`define DJP_PWR_JOY_BIT 2
`define DJP_BIT_S1_X 0
`define DJP_BIT_S1_Y 1
`define DJP_BIT_S2_X 2
`define DJP_BIT_S2_Y 3
`define DJP_BIT_S1_B1 4
`define DJP_BIT_S1_B2 5
`define DJP_BIT_S2_B1 6
`define DJP_BIT_S2_B2 7

// ------------------------------------------------
// offsets and reset values
// ------------------------------------------------
`define DJP_STATE_OFFSET 16'h0000
`define DJP_STATE_RESET 8'h00
`define DJP_BASE_RESET 8'h00
`define DJP_ACT_RESET 1'b0

// ------------------------------------------------
// timing
// ------------------------------------------------
`define DJP_CLK_MHZ 250
`define DJP_DISCH_NS 1000
`define DJP_DISCH_CYC ((`DJP_DISCH_NS * `DJP_CLK_MHZ + 999) / 1000)

`endif

// ===== src/djp_joystick_port.sv
/*
  Dual joystick port: host I/O decode, configuration bytes, pin
  synchronisers, four axis timers and the read-only joystick state byte.
  Assumes host I/O and configuration strobes are levels on i_ref_clk;
  timing comparators and buttons are asynchronous pins.
*/
`timescale 1ns/1ps
`include "djp_cfg.svh"

module djp_joystick_port #(
  parameter int DISCH_CYC = `DJP_DISCH_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  output logic [7:0] o_io_rdata,
  output logic o_io_rd_hit,
  input wire logic [7:0] i_cfg_index,
  input wire logic i_cfg_rd,
  input wire logic i_cfg_wr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  input wire logic [1:0] i_x_axis_timing_pin,
  input wire logic [1:0] i_y_axis_timing_pin,
  output logic [1:0] o_x_axis_timing_pin,
  output logic [1:0] o_x_axis_timing_pin_oe_n,
  output logic [1:0] o_y_axis_timing_pin,
  output logic [1:0] o_y_axis_timing_pin_oe_n,
  input wire logic i_stick1_button_one,
  input wire logic i_stick1_button_two,
  input wire logic i_stick2_button_one,
  input wire logic i_stick2_button_two,
  output logic [7:0] o_joystick_state,
  output logic o_joystick_active
);

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic io_hit(input logic [15:0] addr, input logic [15:0] base,
                                  input logic active);
    io_hit = active && (addr == 16'(base + `DJP_STATE_OFFSET));
  endfunction

  // ------------------------------------------------
  // declarations
  // ------------------------------------------------
  djp_pkg::djp_byte_t base_hi_r;
  djp_pkg::djp_byte_t base_lo_r;
  logic active_r;
  logic [7:0] pins_meta_r;
  logic [7:0] pins_sync_r;
  logic wr_hit_r;
  logic [1:0] pin_low_r;
  logic [3:0] timer_bit;
  logic [3:0] dis_oe_n;
  logic [3:0] above;
  logic [15:0] base_addr;
  logic joystick_read_strobe;
  logic joystick_write_strobe;
  logic discharge_trig;
  logic cfg_wr_hi;
  logic cfg_wr_lo;
  logic cfg_wr_act;
  logic active_nxt;
  djp_pkg::djp_byte_t state_byte;
  djp_pkg::djp_byte_t cfg_rd_mux;
  djp_pkg::djp_byte_t io_rd_mux;

  // ------------------------------------------------
  // address decode
  // ------------------------------------------------
  assign base_addr = {base_hi_r, base_lo_r};
  assign joystick_read_strobe = i_io_rd && io_hit(i_io_addr, base_addr, active_r);
  assign joystick_write_strobe = i_io_wr && io_hit(i_io_addr, base_addr, active_r);
  assign discharge_trig = wr_hit_r && !i_io_wr;

  // ------------------------------------------------
  // configuration bytes
  // ------------------------------------------------
  assign cfg_wr_hi = i_cfg_wr && (i_cfg_index == `DJP_IDX_BASE_HI);
  assign cfg_wr_lo = i_cfg_wr && (i_cfg_index == `DJP_IDX_BASE_LO);
  assign cfg_wr_act = i_cfg_wr && (i_cfg_index == `DJP_IDX_ACTIVATE);
  assign active_nxt = cfg_wr_act ? i_cfg_wdata[`DJP_ACT_BIT] :
                      (i_cfg_wr && (i_cfg_index == `DJP_IDX_PWR_CTRL)) ?
                      i_cfg_wdata[`DJP_PWR_JOY_BIT] : active_r;
  assign cfg_rd_mux = (i_cfg_index == `DJP_IDX_BASE_HI) ? base_hi_r :
                      (i_cfg_index == `DJP_IDX_BASE_LO) ? base_lo_r :
                      (i_cfg_index == `DJP_IDX_ACTIVATE) ? 8'(active_r) << `DJP_ACT_BIT :
                      (i_cfg_index == `DJP_IDX_PWR_CTRL) ? 8'(active_r) << `DJP_PWR_JOY_BIT :
                      8'h00;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      base_hi_r <= `DJP_BASE_RESET;
      base_lo_r <= `DJP_BASE_RESET;
      active_r <= `DJP_ACT_RESET;
    end else begin
      if (cfg_wr_hi) begin
        base_hi_r <= i_cfg_wdata;
      end
      if (cfg_wr_lo) begin
        base_lo_r <= i_cfg_wdata;
      end
      active_r <= active_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_cfg_rdata <= 8'h00;
      o_joystick_active <= `DJP_ACT_RESET;
    end else begin
      o_cfg_rdata <= i_cfg_rd ? cfg_rd_mux : 8'h00;
      o_joystick_active <= active_nxt;
    end
  end

  // ------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pins_meta_r <= 8'h00;
      pins_sync_r <= 8'h00;
    end else begin
      pins_meta_r <= {i_stick2_button_two, i_stick2_button_one,
                      i_stick1_button_two, i_stick1_button_one,
                      i_y_axis_timing_pin[1], i_x_axis_timing_pin[1],
                      i_y_axis_timing_pin[0], i_x_axis_timing_pin[0]};
      pins_sync_r <= pins_meta_r;
    end
  end

  assign above = pins_sync_r[3:0];

  // ------------------------------------------------
  // axis timers
  // ------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_axis
    djp_axis_timer #(
      .DISCH_CYC(DISCH_CYC)
    ) u_timer (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_trigger(discharge_trig),
      .i_above_threshold(above[g]),
      .o_timer_out(timer_bit[g]),
      .o_discharge_oe_n(dis_oe_n[g])
    );
  end

  assign o_x_axis_timing_pin_oe_n = {dis_oe_n[`DJP_BIT_S2_X], dis_oe_n[`DJP_BIT_S1_X]};
  assign o_y_axis_timing_pin_oe_n = {dis_oe_n[`DJP_BIT_S2_Y], dis_oe_n[`DJP_BIT_S1_Y]};
  assign o_x_axis_timing_pin = pin_low_r;
  assign o_y_axis_timing_pin = pin_low_r;

  // ------------------------------------------------
  // state byte and host read
  // ------------------------------------------------
  assign state_byte = {pins_sync_r[`DJP_BIT_S2_B2], pins_sync_r[`DJP_BIT_S2_B1],
                       pins_sync_r[`DJP_BIT_S1_B2], pins_sync_r[`DJP_BIT_S1_B1],
                       timer_bit[`DJP_BIT_S2_Y], timer_bit[`DJP_BIT_S2_X],
                       timer_bit[`DJP_BIT_S1_Y], timer_bit[`DJP_BIT_S1_X]};
  assign io_rd_mux = joystick_read_strobe ? state_byte : 8'h00;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_hit_r <= 1'b0;
      pin_low_r <= 2'b00;
      o_io_rdata <= `DJP_STATE_RESET;
      o_io_rd_hit <= 1'b0;
      o_joystick_state <= `DJP_STATE_RESET;
    end else begin
      wr_hit_r <= joystick_write_strobe;
      pin_low_r <= 2'b00;
      o_io_rdata <= io_rd_mux;
      o_io_rd_hit <= joystick_read_strobe;
      o_joystick_state <= state_byte;
    end
  end

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  property p_state_map;
    @(posedge i_ref_clk) disable iff (i_reset)
    $rose(timer_bit[2]) |-> ##1 o_joystick_state[2] && (o_joystick_state[7:4] ==
      {$past(pins_sync_r[7]), $past(pins_sync_r[6]), $past(pins_sync_r[5]),
       $past(pins_sync_r[4])});
  endproperty
  a_state_map: assert property (p_state_map)
    else $error("state byte field mapping wrong");

  property p_read_value;
    @(posedge i_ref_clk) disable iff (i_reset)
    joystick_read_strobe |=> o_io_rd_hit && (o_io_rdata == o_joystick_state);
  endproperty
  a_read_value: assert property (p_read_value)
    else $error("host read does not return live state");

  property p_write_discharge;
    @(posedge i_ref_clk) disable iff (i_reset)
    (wr_hit_r && !i_io_wr) |=> (dis_oe_n == 4'h0) && (timer_bit == 4'hF);
  endproperty
  a_write_discharge: assert property (p_write_discharge)
    else $error("write trailing edge did not discharge all pins");

  property p_no_early_discharge;
    @(posedge i_ref_clk) disable iff (i_reset)
    (joystick_write_strobe && dis_oe_n[0]) |=> dis_oe_n[0] || !timer_bit[0];
  endproperty
  a_no_early_discharge: assert property (p_no_early_discharge)
    else $error("discharge began before write strobe ended");

  property p_threshold;
    @(posedge i_ref_clk) disable iff (i_reset)
    (dis_oe_n[1] && above[1] && !discharge_trig) |=> !timer_bit[1] && !dis_oe_n[1];
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("axis timer ignored threshold");

  property p_decode_addr;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_io_rd && (i_io_addr != {base_hi_r, base_lo_r})) |=> !o_io_rd_hit;
  endproperty
  a_decode_addr: assert property (p_decode_addr)
    else $error("read answered at wrong address");

  property p_base_bytes;
    @(posedge i_ref_clk) disable iff (i_reset)
    cfg_wr_hi |=> base_addr == {$past(i_cfg_wdata), $past(base_lo_r)};
  endproperty
  a_base_bytes: assert property (p_base_bytes)
    else $error("base address high byte not applied");

  property p_inactive;
    @(posedge i_ref_clk) disable iff (i_reset)
    (!active_r && (i_io_rd || i_io_wr)) |=> !o_io_rd_hit && !wr_hit_r;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("decode while not activated");

  property p_mirror;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_cfg_wr && (i_cfg_index == `DJP_IDX_PWR_CTRL)) |=>
      (active_r == $past(i_cfg_wdata[`DJP_PWR_JOY_BIT])) && (o_joystick_active == active_r);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("activate bit does not mirror power control bit");

  property p_reset_value;
    @(posedge i_ref_clk)
    i_reset |=> o_joystick_state == 8'h00 && o_io_rdata == 8'h00;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("state not 00h after reset");

  property p_hold_high;
    @(posedge i_ref_clk) disable iff (i_reset)
    (dis_oe_n[3] && !above[3]) |=> timer_bit[3];
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("axis bit fell before threshold");

  property p_decode_hit;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_io_rd && active_r && (i_io_addr == {base_hi_r, base_lo_r})) |=>
      o_io_rd_hit && (o_io_rdata == $past(state_byte));
  endproperty
  a_decode_hit: assert property (p_decode_hit)
    else $error("read at base address not answered");

  property p_pins_low;
    @(posedge i_ref_clk) disable iff (i_reset)
    discharge_trig |=> (o_x_axis_timing_pin == 2'b00) && (o_y_axis_timing_pin == 2'b00) &&
      (o_x_axis_timing_pin_oe_n == 2'b00) && (o_y_axis_timing_pin_oe_n == 2'b00);
  endproperty
  a_pins_low: assert property (p_pins_low)
    else $error("timing pins not driven low after write");

  property p_trigger_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
    discharge_trig |=> (timer_bit == 4'hF) [*2];
  endproperty
  a_trigger_hold: assert property (p_trigger_hold)
    else $error("axis bits not held high after discharge");

  property p_reset_pins;
    @(posedge i_ref_clk)
    i_reset |=> (dis_oe_n == 4'h0) && (timer_bit == 4'h0) && !o_io_rd_hit;
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("pins or axis bits wrong after reset");

endmodule

// ===== src/djp_pkg.sv
/*
  Types shared by the dual joystick port modules.
  Assumes djp_cfg.svh carries the numeric constants.
*/
package djp_pkg;

  typedef enum logic [1:0] {
    DJP_IDLE,
    DJP_DISCHARGE,
    DJP_CHARGE
  } djp_axis_state_t;

  typedef logic [7:0] djp_byte_t;

endpackage

// ===== verif/djp_stick_model.sv
/*
  Model of two joysticks: four RC timing pins and their threshold compare.
  Assumes the port drives each pin low while its oe_n is low.
*/
`timescale 1ns/1ps

module djp_stick_model (
  input wire logic i_ref_clk,
  input wire logic [1:0] i_x_drive,
  input wire logic [1:0] i_x_oe_n,
  input wire logic [1:0] i_y_drive,
  input wire logic [1:0] i_y_oe_n,
  input wire logic [31:0] i_charge_cyc,
  output logic [1:0] o_x_above,
  output logic [1:0] o_y_above
);
  logic [3:0] held_low;
  logic [3:0] above;
  int cnt [4];

  // ------------------------------------------------
  // pin charge
  // ------------------------------------------------
  // two sticks, x and y pin each
  assign held_low = {~i_y_oe_n[1] & ~i_y_drive[1], ~i_x_oe_n[1] & ~i_x_drive[1],
                     ~i_y_oe_n[0] & ~i_y_drive[0], ~i_x_oe_n[0] & ~i_x_drive[0]};
  always @(posedge i_ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (held_low[k] !== 1'b0) begin
        cnt[k] <= 0;
      end else if (cnt[k] < 255) begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
  // pin at two thirds once charge time is spent
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      above[k] = (held_low[k] === 1'b0) && (cnt[k] >= int'(i_charge_cyc[k*8 +: 8]));
    end
  end
  assign o_x_above = {above[2], above[0]};
  assign o_y_above = {above[3], above[1]};
endmodule

// ===== verif/testbench.sv
/*
  Self-checking bench for the dual joystick port.
  Assumes the port and the joystick model are compiled before it.
*/
`timescale 1ns/1ps

module testbench;
  localparam int DC = 4;
  logic i_ref_clk, i_reset, i_io_rd, i_io_wr, i_cfg_rd, i_cfg_wr, o_io_rd_hit, o_joystick_active;
  logic [15:0] i_io_addr, base;
  logic [7:0] i_cfg_index, i_cfg_wdata, o_io_rdata, o_cfg_rdata, o_joystick_state, got;
  logic [1:0] x_in, y_in, x_drv, x_oe_n, y_drv, y_oe_n;
  logic [3:0] btn, oe4;
  logic [31:0] chg;
  logic h;
  int fail_count, comparisons, seed, cyc, t0;
  int fall [4];

  djp_joystick_port #(.DISCH_CYC(DC)) djp_joystick_port_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
    .i_io_wr(i_io_wr), .o_io_rdata(o_io_rdata), .o_io_rd_hit(o_io_rd_hit),
    .i_cfg_index(i_cfg_index), .i_cfg_rd(i_cfg_rd), .i_cfg_wr(i_cfg_wr),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .i_x_axis_timing_pin(x_in),
    .i_y_axis_timing_pin(y_in), .o_x_axis_timing_pin(x_drv), .o_x_axis_timing_pin_oe_n(x_oe_n),
    .o_y_axis_timing_pin(y_drv), .o_y_axis_timing_pin_oe_n(y_oe_n),
    .i_stick1_button_one(btn[0]), .i_stick1_button_two(btn[1]),
    .i_stick2_button_one(btn[2]), .i_stick2_button_two(btn[3]),
    .o_joystick_state(o_joystick_state), .o_joystick_active(o_joystick_active));

  djp_stick_model djp_stick_model_inst (
    .i_ref_clk(i_ref_clk), .i_x_drive(x_drv), .i_x_oe_n(x_oe_n), .i_y_drive(y_drv),
    .i_y_oe_n(y_oe_n), .i_charge_cyc(chg), .o_x_above(x_in), .o_y_above(y_in));

  assign oe4 = {y_oe_n[1], x_oe_n[1], y_oe_n[0], x_oe_n[0]};

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_index <= idx;
    i_cfg_wdata <= d;
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'b0;
  endtask

  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_cfg_rd <= 1'b1;
    i_cfg_index <= idx;
    @(posedge i_ref_clk);
    i_cfg_rd <= 1'b0;
    #1 d = o_cfg_rdata;
  endtask

  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic hit);
    @(posedge i_ref_clk);
    i_io_rd <= 1'b1;
    i_io_addr <= a;
    @(posedge i_ref_clk);
    i_io_rd <= 1'b0;
    #1 d = o_io_rdata;
    hit = o_io_rd_hit;
  endtask

  task automatic io_wr(input logic [15:0] a);
    @(posedge i_ref_clk);
    i_io_wr <= 1'b1;
    i_io_addr <= a;
    i_cfg_wdata <= 8'($random(seed));
    @(posedge i_ref_clk);
    i_io_wr <= 1'b0;
  endtask

  function automatic logic [7:0] in_win(input int d);
    return (d >= DC + 1 && d <= DC + 10) ? 8'h01 : 8'h00;
  endfunction

  // ------------------------------------------------
  // clock, cycle count, watchdog
  // ------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    fail_count++;
    print_verdict();
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    seed = 32'hA999;
    cyc = 0;
    {i_reset, i_io_rd, i_io_wr, i_cfg_rd, i_cfg_wr} = 5'h10;
    {i_io_addr, i_cfg_index, i_cfg_wdata, btn, chg} = '0;
    repeat (6) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    #1 cmp8(o_joystick_state, 8'h00);
    io_wr(16'h0000);
    repeat (4) @(posedge i_ref_clk);
    #1 cmp8(o_joystick_state, 8'h00);
    io_rd(16'h0000, got, h);
    cmp8({7'h00, h}, 8'h00);
    base = 16'($random(seed));
    cfg_wr(8'h60, base[15:8]);
    cfg_wr(8'h61, base[7:0]);
    cfg_rd(8'h60, got);
    cmp8(got, base[15:8]);
    cfg_rd(8'h61, got);
    cmp8(got, base[7:0]);
    cfg_wr(8'h22, 8'h04);
    cfg_rd(8'h30, got);
    cmp8(got, 8'h01);
    cmp8({7'h00, o_joystick_active}, 8'h01);
    cfg_wr(8'h30, 8'h00);
    cfg_rd(8'h22, got);
    cmp8(got, 8'h00);
    cfg_wr(8'h30, 8'h01);
    cfg_rd(8'h22, got);
    cmp8(got, 8'h04);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_ref_clk);
      btn <= (i == 0) ? 4'hF : 4'($random(seed));
      repeat (5) @(posedge i_ref_clk);
      io_rd(base, got, h);
      cmp8(got, {btn, 4'h0});
      cmp8({7'h00, h}, 8'h01);
    end
    io_wr(base ^ 16'h0001);
    repeat (4) @(posedge i_ref_clk);
    #1 cmp8(o_joystick_state, {btn, 4'h0});
    io_rd(base ^ 16'h0001, got, h);
    cmp8({7'h00, h}, 8'h00);
    cmp8(got, 8'h00);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_ref_clk);
      for (int k = 0; k < 4; k++) chg[k*8 +: 8] <= 8'd10 + 8'($unsigned($random(seed)) % 32);
      io_wr(base);
      if (m == 2) begin
        repeat (DC + 2) @(posedge i_ref_clk);
        io_wr(base);
      end
      t0 = cyc;
      @(posedge i_ref_clk);
      #1 cmp8({4'h0, oe4}, 8'h00);
      cmp8({4'h0, y_drv, x_drv}, 8'h00);
      io_rd(base, got, h);
      cmp8(got, {btn, 4'hF});
      for (int k = 0; k < 4; k++) fall[k] = -1;
      for (int n = 0; n < 300; n++) begin
        @(posedge i_ref_clk);
        #1;
        for (int k = 0; k < 4; k++) begin
          if (fall[k] < 0 && o_joystick_state[k] === 1'b0) begin
            fall[k] = cyc;
            cmp8({7'h00, oe4[k]}, 8'h00);
          end
        end
      end
      for (int k = 0; k < 4; k++) cmp8(in_win(fall[k] - t0 - int'(chg[k*8 +: 8])), 8'h01);
      io_rd(base, got, h);
      cmp8(got, {btn, 4'h0});
    end
    io_wr(base);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    #1 cmp8(o_joystick_state, 8'h00);
    cmp8({3'h0, o_joystick_active, oe4}, 8'h00);
    print_verdict();
  end
endmodule
